// ---- rtl/fbi_core.sv ----
// Instruction execution core of the 4-bit controller: sequencing, stack,
// timers, control registers and a small software port.
// Assumes rom_data and ram_rdata answer combinationally to their addresses.
//
// How it works
// - A true skip voids the next instruction; the counter still steps by one.
// - A voided instruction other than a table read or return keeps its own cycle count.
// - A voided table read, return or return-with-skip takes one cycle.
// - Counter is 4-bit page plus 7-bit in-page; short jumps keep page.
// - Four 11-bit stack entries, 2-bit index; push pre-increments, pop post-decrements.
// - RAM address is row register above column register, six bits.
// - Table read moves ROM bits to B and A, top bit to carry if enabled.
// - Timer-1 load while stopped writes reload and counter.
// - Timer-1 load while running writes only the reload.
// - Timer-1 flag test skips when set and clears the flag.
// - Timer-2 has its own underflow flag and skip test.
// - Two-bit select picks XOR, OR or AND for the logic operation.
// - Timer control one is three bits from A, control two four bits.
// - Each pull-down control register loads four bits from A.
// - A pull-down bit enables both pull-down and key-on wakeup.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module fbi_core
    import fbi_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire fbi_pkg::fbi_bus_req_type bus_req,
    output logic [31:0]                  rd_data,
    output logic                         irq,
    output logic [fbi_pkg::PC_W-1:0]     rom_addr,
    input  wire logic [fbi_pkg::ROM_W-1:0] rom_data,
    output logic [5:0]                   ram_addr,
    input  wire logic [3:0]              ram_rdata,
    output logic [3:0]                   ram_wdata,
    output logic                         ram_we,
    output logic [7:0]                   pulldown_en,
    output logic [7:0]                   wakeup_en
);
    import fbi_pkg::*;

    fbi_state_type s_r;
    fbi_state_type s_nxt;
    logic [10:0]   pc;
    logic [10:0]   pc1;
    logic [8:0]    op;
    logic          is_two;
    logic          is_ret;
    logic          exec;
    logic          t1_uf;
    logic          t2_uf;
    logic [1:0]    sp_inc;
    logic [4:0]    sum;
    logic          we_c;

    assign pc = {s_r.page, s_r.inpage};
    assign pc1 = pc + 11'h001;
    assign op = rom_data;
    assign exec = (s_r.phase == PH_EXEC) && s_r.run;
    assign sp_inc = s_r.sp + 2'h1;
    assign t1_uf = s_r.tc1[0] && (s_r.t1_cnt == 8'h00);
    assign t2_uf = s_r.tc2[0] && (s_r.t2_cnt == 8'h00);
    assign is_two = (op == OP_BA) || (op == OP_BLA) || (op == OP_BMLA)
                    || (op[8:4] == OPH_BL) || (op[8:4] == OPH_BML);
    assign is_ret = (op[8:4] == OPH_TABLE_REFERENCE_OP) || (op == OP_RT) || (op == OP_RTS);

    // Table read points the counter at the looked-up word, so one path serves both
    assign rom_addr = pc;
    assign ram_addr = {s_r.x, s_r.y};
    assign ram_wdata = s_r.a;
    assign ram_we = we_c;
    assign rd_data = s_r.rdata;
    assign irq = |(s_r.ev_stat & s_r.ev_en);
    assign pulldown_en = {s_r.pd_hi, s_r.pd_lo};
    assign wakeup_en = {s_r.pd_hi, s_r.pd_lo};

    always_comb begin
        s_nxt = s_r;
        we_c = 1'b0;
        sum = {1'b0, s_r.a} + {1'b0, op[3:0]};

        // Timers count every clock while their run bit is set
        if (s_r.tc1[0]) begin
            s_nxt.t1_cnt = t1_uf ? s_r.t1_rel : s_r.t1_cnt - 8'h01;
        end
        if (s_r.tc2[0]) begin
            s_nxt.t2_cnt = t2_uf ? s_r.t2_rel : s_r.t2_cnt - 8'h01;
        end

        case (s_r.phase)
            PH_EXEC: begin
                if (s_r.run) begin
                    {s_nxt.page, s_nxt.inpage} = pc1;
                    s_nxt.skip = 1'b0;
                    s_nxt.w1 = op;
                    if (s_r.skip) begin
                        if (is_two) begin
                            s_nxt.phase = PH_WORD2;
                            s_nxt.kill = 1'b1;
                        end
                        // Voided table read or return ends here
                        if (is_ret) begin
                            s_nxt.phase = PH_EXEC;
                        end
                    end else if (is_two) begin
                        s_nxt.phase = PH_WORD2;
                    end else if (op[8]) begin
                        if (op[7]) begin
                            s_nxt.inpage = op[6:0];
                        end else begin
                            s_nxt.sp = sp_inc;
                            s_nxt.stack[sp_inc] = pc1;
                            s_nxt.page = BM_PAGE;
                            s_nxt.inpage = op[6:0];
                        end
                    end else if (op[8:4] == OPH_TABLE_REFERENCE_OP) begin
                        s_nxt.sp = sp_inc;
                        s_nxt.stack[sp_inc] = pc1;
                        s_nxt.page = op[3:0];
                        s_nxt.inpage = {s_r.dr, s_r.a};
                        s_nxt.phase = PH_TAB;
                    end else if (op[8:4] == OPH_LA) begin
                        s_nxt.a = op[3:0];
                    end else if (op[8:4] == OPH_A) begin
                        s_nxt.a = sum[3:0];
                        s_nxt.skip = ~sum[4];
                    end else if (op[8:6] == OPH_LXY) begin
                        s_nxt.x = op[5:4];
                        s_nxt.y = op[3:0];
                    end else begin
                        case (op)
                            OP_AM: s_nxt.a = s_r.a + ram_rdata;
                            OP_TDA: s_nxt.dr = s_r.a[2:0];
                            OP_SZC: s_nxt.skip = ~s_r.cy;
                            OP_TMA: we_c = 1'b1;
                            OP_TBA: s_nxt.b = s_r.a;
                            OP_TAM: s_nxt.a = ram_rdata;
                            OP_SC: s_nxt.cy = 1'b1;
                            OP_RC: s_nxt.cy = 1'b0;
                            OP_RT, OP_RTS: begin
                                {s_nxt.page, s_nxt.inpage} = s_r.stack[s_r.sp];
                                s_nxt.sp = s_r.sp - 2'h1;
                                s_nxt.skip = (op == OP_RTS);
                                s_nxt.phase = PH_RET;
                            end
                            OP_TIMER_ONE_LOAD_OP: begin
                                s_nxt.t1_rel = {s_r.b, s_r.a};
                                if (!s_r.tc1[0]) begin
                                    s_nxt.t1_cnt = {s_r.b, s_r.a};
                                end
                            end
                            OP_T2AB: begin
                                s_nxt.t2_rel = {s_r.b, s_r.a};
                                s_nxt.t2_cnt = {s_r.b, s_r.a};
                            end
                            OP_TIMER_ONE_FLAG_TEST_OP: begin
                                s_nxt.skip = s_r.t1f;
                                s_nxt.t1f = 1'b0;
                            end
                            OP_SNZT2: begin
                                s_nxt.skip = s_r.t2f;
                                s_nxt.t2f = 1'b0;
                            end
                            OP_TIMER_CTRL_ONE_LOAD_OP: s_nxt.tc1 = s_r.a[2:0];
                            OP_TV2A: s_nxt.tc2 = s_r.a;
                            OP_TLOA: s_nxt.lo = s_r.a[1:0];
                            OP_LOGIC_OPERATION_OP: begin
                                case (s_r.lo)
                                    LO_XOR: s_nxt.a = s_r.a ^ ram_rdata;
                                    LO_OR: s_nxt.a = s_r.a | ram_rdata;
                                    default: s_nxt.a = s_r.a & ram_rdata;
                                endcase
                            end
                            OP_TPU0A: s_nxt.pd_lo = s_r.a;
                            OP_TPU1A: s_nxt.pd_hi = s_r.a;
                            OP_URSC: s_nxt.rom_top_bit_enable = 1'b1;
                            default: s_nxt.kill = s_r.kill;
                        endcase
                    end
                end
            end
            PH_WORD2: begin
                {s_nxt.page, s_nxt.inpage} = pc1;
                s_nxt.phase = PH_EXEC;
                s_nxt.kill = 1'b0;
                if (!s_r.kill) begin
                    if ((s_r.w1[8:4] == OPH_BML) || (s_r.w1 == OP_BMLA)) begin
                        s_nxt.sp = sp_inc;
                        s_nxt.stack[sp_inc] = pc1;
                    end
                    if ((s_r.w1 == OP_BA) || (s_r.w1 == OP_BLA) || (s_r.w1 == OP_BMLA)) begin
                        s_nxt.inpage = {op[6:4], s_r.a};
                    end else begin
                        s_nxt.inpage = op[6:0];
                    end
                    // Long forms also load the page
                    if ((s_r.w1 == OP_BLA) || (s_r.w1 == OP_BMLA)) begin
                        s_nxt.page = op[3:0];
                    end else if (s_r.w1 != OP_BA) begin
                        s_nxt.page = s_r.w1[3:0];
                    end
                end
            end
            PH_TAB: begin
                s_nxt.b = op[7:4];
                s_nxt.a = op[3:0];
                if (s_r.rom_top_bit_enable) begin
                    s_nxt.cy = op[8];
                end
                {s_nxt.page, s_nxt.inpage} = s_r.stack[s_r.sp];
                s_nxt.sp = s_r.sp - 2'h1;
                s_nxt.phase = PH_RET;
            end
            PH_RET: s_nxt.phase = PH_EXEC;
            default: s_nxt.phase = PH_EXEC;
        endcase

        // Software port; event clears come before sets so a new event survives
        s_nxt.rdata = 32'h0000_0000;
        if (bus_req.wr) begin
            case (bus_req.addr)
                REG_CLR: s_nxt.ev_stat = s_r.ev_stat & ~bus_req.wdata[1:0];
                REG_EN: s_nxt.ev_en = bus_req.wdata[1:0];
                REG_CTRL: s_nxt.run = bus_req.wdata[CTRL_RUN];
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                REG_STATUS: s_nxt.rdata = {30'h0, s_r.ev_stat};
                REG_EN: s_nxt.rdata = {30'h0, s_r.ev_en};
                REG_CTRL: s_nxt.rdata = {31'h0, s_r.run};
                REG_CORE: s_nxt.rdata = {6'h0, s_r.skip, s_r.cy, s_r.b, s_r.a,
                                         2'h0, s_r.sp, 1'b0, pc};
                REG_CFG: s_nxt.rdata = {9'h0, s_r.t2f, s_r.t1f, s_r.rom_top_bit_enable, s_r.pd_hi,
                                        s_r.pd_lo, s_r.tc2, 1'b0, s_r.tc1, 2'h0, s_r.lo};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (t1_uf) begin
            s_nxt.t1f = 1'b1;
            s_nxt.ev_stat[EV_T1] = 1'b1;
        end
        if (t2_uf) begin
            s_nxt.t2f = 1'b1;
            s_nxt.ev_stat[EV_T2] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    skip_no_effect_a: assert property (
        exec && s_r.skip && !is_two |=> (pc == $past(pc1)) && (s_r.a == $past(s_r.a))
                                         && (s_r.sp == $past(s_r.sp)))
        else $error("voided instruction changed state");
    skip_two_cyc_a: assert property (
        exec && s_r.skip && is_two |=> (s_r.phase == PH_WORD2) ##1 (s_r.phase == PH_EXEC))
        else $error("voided two-word instruction wrong length");
    skip_ret_one_a: assert property (
        exec && s_r.skip && is_ret |=> (s_r.phase == PH_EXEC) && (pc == $past(pc1)))
        else $error("voided return not one cycle");
    short_branch_a: assert property (
        exec && !s_r.skip && op[8] && op[7]
        |=> (s_r.page == $past(s_r.page)) && (s_r.inpage == $past(op[6:0])))
        else $error("short branch wrong target");
    call_push_a: assert property (
        exec && !s_r.skip && op[8] && !op[7]
        |=> (s_r.sp == $past(sp_inc)) && (s_r.stack[s_r.sp] == $past(pc1)) && (s_r.page == BM_PAGE))
        else $error("call push wrong");
    tab_carry_a: assert property (
        (s_r.phase == PH_TAB) |=> (s_r.cy == ($past(s_r.rom_top_bit_enable) ? $past(op[8]) : $past(s_r.cy)))
                                  && ({s_r.b, s_r.a} == $past(op[7:0])) ##1 (s_r.phase == PH_EXEC))
        else $error("table read data or carry wrong");
    t1_load_stop_a: assert property (
        exec && !s_r.skip && (op == OP_TIMER_ONE_LOAD_OP) && !s_r.tc1[0]
        |=> (s_r.t1_cnt == $past({s_r.b, s_r.a})) && (s_r.t1_rel == $past({s_r.b, s_r.a})))
        else $error("stopped timer load wrong");
    t1_load_run_a: assert property (
        exec && !s_r.skip && (op == OP_TIMER_ONE_LOAD_OP) && s_r.tc1[0]
        |=> (s_r.t1_rel == $past({s_r.b, s_r.a}))
            && ((s_r.t1_cnt == $past(s_r.t1_cnt) - 8'h01) || (s_r.t1_cnt == $past(s_r.t1_rel))))
        else $error("running timer load disturbed counter");
    t1_test_a: assert property (
        exec && !s_r.skip && (op == OP_TIMER_ONE_FLAG_TEST_OP) && !t1_uf |=> (s_r.skip == $past(s_r.t1f)) && !s_r.t1f)
        else $error("timer-1 flag test wrong");
    logic_xor_a: assert property (
        exec && !s_r.skip && (op == OP_LOGIC_OPERATION_OP) && (s_r.lo == LO_XOR)
        |=> s_r.a == ($past(s_r.a) ^ $past(ram_rdata)))
        else $error("logic operation select wrong");

    skip_one_cyc_a: assert property (
        exec && s_r.skip && !is_two && !is_ret |=> (s_r.phase == PH_EXEC))
        else $error("voided one-word instruction wrong length");
    ret_pop_a: assert property (
        exec && !s_r.skip && (op == OP_RT)
        |=> (pc == $past(s_r.stack[s_r.sp])) && (s_r.sp == $past(s_r.sp) - 2'h1) ##1 (s_r.phase == PH_EXEC))
        else $error("return pop wrong");
    ram_ptr_a: assert property (
        exec && !s_r.skip && (op[8:6] == OPH_LXY) |=> (ram_addr == $past(op[5:0])))
        else $error("RAM pointer not row above column");
    t1_flag_set_a: assert property (
        t1_uf |=> s_r.t1f && s_r.ev_stat[EV_T1])
        else $error("timer-1 underflow not flagged");
    t2_flag_set_a: assert property (
        t2_uf |=> s_r.t2f && s_r.ev_stat[EV_T2])
        else $error("timer-2 underflow not flagged");
    t2_test_a: assert property (
        exec && !s_r.skip && (op == OP_SNZT2) && !t2_uf |=> (s_r.skip == $past(s_r.t2f)) && !s_r.t2f)
        else $error("timer-2 flag test wrong");
    tc_load_a: assert property (
        exec && !s_r.skip && (op == OP_TIMER_CTRL_ONE_LOAD_OP) |=> (s_r.tc1 == $past(s_r.a[2:0])))
        else $error("timer control one load wrong");
    pd_wake_a: assert property (
        exec && !s_r.skip && (op == OP_TPU1A)
        |=> (pulldown_en[7:4] == $past(s_r.a)) && (wakeup_en[7:4] == $past(s_r.a)))
        else $error("pull-down or wakeup enable wrong");

    cov_skip_two_c: cover property (exec && s_r.skip && is_two);
    cov_tab_urs_c: cover property ((s_r.phase == PH_TAB) && s_r.rom_top_bit_enable);
    cov_wrap_c: cover property (exec && op[8] && !op[7] && (s_r.sp == 2'h3));
    cov_t2_skip_c: cover property (exec && (op == OP_SNZT2) && s_r.t2f);
    cov_rts_void_c: cover property ((s_r.phase == PH_RET) && s_r.skip);
endmodule // fbi_core

// ---- rtl/fbi_pkg.sv ----
// Constants, opcodes, register map and state carrier of the 4-bit core.
// Assumes one clock domain and ROM/RAM that answer within the cycle.
package fbi_pkg;

    localparam int PC_W = 11;
    localparam int ROM_W = 9;
    localparam int BUS_AW = 8;

    // Register map, byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CLR = 8'h04;
    localparam logic [7:0] REG_EN = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_CORE = 8'h10;
    localparam logic [7:0] REG_CFG = 8'h14;
    localparam int EV_T1 = 0;
    localparam int EV_T2 = 1;
    localparam int CTRL_RUN = 0;

    // Opcode fields: upper bits of the first word
    localparam logic [4:0] OPH_BL = 5'h03;
    localparam logic [4:0] OPH_A = 5'h06;
    localparam logic [4:0] OPH_BML = 5'h07;
    localparam logic [4:0] OPH_TABLE_REFERENCE_OP = 5'h08;
    localparam logic [4:0] OPH_LA = 5'h0A;
    localparam logic [2:0] OPH_LXY = 3'h3;
    localparam logic [3:0] BM_PAGE = 4'h2;
    // Whole-word opcodes
    localparam logic [8:0] OP_NOP = 9'h000;
    localparam logic [8:0] OP_BA = 9'h001;
    localparam logic [8:0] OP_AM = 9'h00A;
    localparam logic [8:0] OP_BLA = 9'h010;
    localparam logic [8:0] OP_TDA = 9'h020;
    localparam logic [8:0] OP_SZC = 9'h021;
    localparam logic [8:0] OP_TMA = 9'h022;
    localparam logic [8:0] OP_T2AB = 9'h023;
    localparam logic [8:0] OP_TBA = 9'h040;
    localparam logic [8:0] OP_TAM = 9'h041;
    localparam logic [8:0] OP_SC = 9'h042;
    localparam logic [8:0] OP_RC = 9'h043;
    localparam logic [8:0] OP_RT = 9'h044;
    localparam logic [8:0] OP_RTS = 9'h045;
    localparam logic [8:0] OP_TIMER_ONE_LOAD_OP = 9'h046;
    localparam logic [8:0] OP_TIMER_ONE_FLAG_TEST_OP = 9'h047;
    localparam logic [8:0] OP_SNZT2 = 9'h048;
    localparam logic [8:0] OP_TIMER_CTRL_ONE_LOAD_OP = 9'h049;
    localparam logic [8:0] OP_TV2A = 9'h04A;
    localparam logic [8:0] OP_TLOA = 9'h04B;
    localparam logic [8:0] OP_LOGIC_OPERATION_OP = 9'h04C;
    localparam logic [8:0] OP_TPU0A = 9'h04D;
    localparam logic [8:0] OP_TPU1A = 9'h04E;
    localparam logic [8:0] OP_URSC = 9'h04F;
    localparam logic [8:0] OP_BMLA = 9'h050;
    localparam logic [1:0] LO_XOR = 2'h0;
    localparam logic [1:0] LO_OR = 2'h1;
    localparam logic [1:0] SP_RST = 2'h3;

    typedef enum logic [1:0] {PH_EXEC, PH_WORD2, PH_TAB, PH_RET} fbi_phase_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fbi_bus_req_type;

    typedef struct packed {
        fbi_phase_type   phase;
        logic            kill;
        logic            skip;
        logic [3:0]      page;
        logic [6:0]      inpage;
        logic [1:0]      sp;
        logic [3:0][10:0] stack;
        logic [3:0]      a;
        logic [3:0]      b;
        logic [1:0]      x;
        logic [3:0]      y;
        logic [2:0]      dr;
        logic            cy;
        logic            rom_top_bit_enable;
        logic [8:0]      w1;
        logic [2:0]      tc1;
        logic [3:0]      tc2;
        logic [1:0]      lo;
        logic [3:0]      pd_lo;
        logic [3:0]      pd_hi;
        logic [7:0]      t1_cnt;
        logic [7:0]      t1_rel;
        logic [7:0]      t2_cnt;
        logic [7:0]      t2_rel;
        logic            t1f;
        logic            t2f;
        logic [1:0]      ev_stat;
        logic [1:0]      ev_en;
        logic            run;
        logic [31:0]     rdata;
    } fbi_state_type;

    localparam fbi_state_type STATE_RST = '{phase: PH_EXEC, sp: SP_RST, run: 1'b1, default: '0};

endpackage

// ---- verif/fbi_mem_model.sv ----
// Behavioural program ROM and data RAM on the far side of the core.
// Assumes the bench fills rom_words before reset is released.
`timescale 1ns/1ps
module fbi_mem_model (
    input  wire logic        clk,
    input  wire logic [10:0] rom_addr,
    output logic [8:0]       rom_data,
    input  wire logic [5:0]  ram_addr,
    output logic [3:0]       ram_rdata,
    input  wire logic [3:0]  ram_wdata,
    input  wire logic        ram_we
);
    logic [8:0] rom_words [0:2047];
    logic [3:0] ram_cells [0:63];

    // Unwritten cells hold all ones, so a missed store cannot read as zero
    initial begin
        for (int i = 0; i < 2048; i++) begin
            rom_words[i] = 9'h000;
        end
        for (int i = 0; i < 64; i++) begin
            ram_cells[i] = 4'hF;
        end
    end

    assign rom_data = rom_words[rom_addr];
    assign ram_rdata = ram_cells[ram_addr];

    always @(posedge clk) begin
        if (ram_we) begin
            ram_cells[ram_addr] <= ram_wdata;
        end
    end
endmodule // fbi_mem_model

// ---- verif/four_bit_instruction_semantics_tb.sv ----
// Self-checking bench: runs a small program from the model ROM, then
// inspects state through the software port and the RAM model.
// Assumes fbi_core and fbi_mem_model; one 250 MHz clock.
`timescale 1ns/1ps
module four_bit_instruction_semantics_tb;
    import fbi_pkg::*;
    localparam int TIMEOUT = 3000;
    logic            clk;
    logic            resetn;
    fbi_bus_req_type bus_req;
    logic [31:0]     rd_data;
    logic            irq;
    logic [10:0]     rom_addr;
    logic [8:0]      rom_data;
    logic [5:0]      ram_addr;
    logic [3:0]      ram_rdata;
    logic [3:0]      ram_wdata;
    logic            ram_we;
    logic [7:0]      pulldown_en;
    logic [7:0]      wakeup_en;
    int              failures;
    int              comparisons;
    int              cycles;
    int              t_one;
    int              t_ten;
    int              t_table_reference_op;
    int              t_after;
    logic [3:0]      r0;
    logic [3:0]      r1;
    logic [3:0]      rl;
    logic [31:0]     d;
    logic [31:0]     rnd;
    logic [8:0]      prog [0:36];
    logic [8:0]      prog2 [0:20];
    logic [19:0]     far_words [0:11];

    fbi_core dut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
        .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .ram_wdata(ram_wdata), .ram_we(ram_we), .pulldown_en(pulldown_en), .wakeup_en(wakeup_en));
    fbi_mem_model mem (.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr),
        .ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_we(ram_we));

    always #2 clk = ~clk;

    task automatic stop_test;
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        v = rd_data;
    endtask

    function automatic logic [31:0] core_word(logic [10:0] pc, logic [1:0] sp, logic [3:0] a,
                                              logic [3:0] b, logic cy);
        return {6'h00, 1'b0, cy, b, a, 2'h0, sp, 1'b0, pc};
    endfunction

    function automatic logic [31:0] cfg_word(logic [1:0] lo, logic [2:0] t1c, logic [3:0] t2c,
                                             logic [3:0] plo, logic [3:0] phi, logic rom_top_bit_enable);
        return {11'h000, rom_top_bit_enable, phi, plo, t2c, 1'b0, t1c, 2'h0, lo};
    endfunction

    // Arrival times at marker addresses give the cycle accounting
    always @(posedge clk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            failures++;
            stop_test();
        end
        if (resetn && rom_addr == 11'h001 && t_one < 0) t_one = cycles;
        if (resetn && rom_addr == 11'h00A && t_ten < 0) t_ten = cycles;
        if (resetn && rom_addr == 11'h021 && t_table_reference_op < 0) t_table_reference_op = cycles;
        if (resetn && rom_addr == 11'h023 && t_after < 0) t_after = cycles;
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        bus_req = '0;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        t_one = -1;
        t_ten = -1;
        t_table_reference_op = -1;
        t_after = -1;
        void'($urandom(99089));
        r0 = 4'($urandom());
        r1 = 4'($urandom());
        rl = 4'($urandom());
        rnd = $urandom();
        // Skip chain, timer wait loop, control loads, table read, then park
        prog = '{9'h0A0, 9'h061, 9'h044, 9'h061, 9'h0A5, 9'h061, 9'h030, 9'h1C0, 9'h061, 9'h080,
                 9'h0D5, 9'h022, 9'h0A8, 9'h046, 9'h0A1, 9'h049, 9'h047, 9'h190, 9'h0A0, 9'h049,
                 {5'h0A, r0}, 9'h04D, {5'h0A, r1}, 9'h04E, {5'h0A, rl}, 9'h04B, 9'h0AE, 9'h049,
                 9'h04A, 9'h0A3, 9'h020, 9'h0A2, 9'h04F, 9'h081, 9'h0D6, 9'h022, 9'h1A4};
        #1;
        for (int i = 0; i < 37; i++) begin
            mem.rom_words[i] = prog[i];
        end
        mem.rom_words[11'h0B2] = 9'h1A5;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 1000 && !(rom_addr == 11'h024 && t_after >= 0); i++) begin
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        chk("skip chain cycles", 32'd9, 32'(t_ten - t_one));
        chk("table read cycles", 32'd4, 32'(t_after - t_table_reference_op));
        chk("ram cell 15", 32'h4, {28'h0, mem.ram_cells[6'h15]});
        chk("ram cell 16", 32'h5, {28'h0, mem.ram_cells[6'h16]});
        bus_read(REG_CORE, d);
        chk("core state", core_word(11'h024, 2'h3, 4'h5, 4'hA, 1'b1), d);
        bus_read(REG_CFG, d);
        chk("config state", cfg_word(rl[1:0], 3'h6, 4'hE, r0, r1, 1'b1), d);
        chk("pulldown pins", {24'h0, r1, r0}, {24'h0, pulldown_en});
        chk("wakeup pins", {24'h0, r1, r0}, {24'h0, wakeup_en});
        bus_read(REG_STATUS, d);
        chk("event status", 32'h1, d);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus_write(REG_EN, 32'h1);
        @(posedge clk);
        #1;
        chk("irq enabled", 32'h1, {31'h0, irq});
        bus_write(REG_EN, 32'h0);
        @(posedge clk);
        #1;
        chk("irq masked again", 32'h0, {31'h0, irq});
        bus_write(REG_EN, 32'h3);
        bus_write(REG_CLR, 32'h1);
        @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus_read(REG_STATUS, d);
        chk("status cleared", 32'h0, d);
        bus_read(REG_EN, d);
        chk("enable readback", 32'h3, d);
        bus_read(8'h20, d);
        chk("unmapped read", 32'h0, d);
        // Read-only core word must ignore a write
        bus_write(REG_CORE, rnd);
        bus_read(REG_CORE, d);
        chk("core after write", core_word(11'h024, 2'h3, 4'h5, 4'hA, 1'b1), d);
        // Mid-run reset, then logic op, calls, returns, long branches and timer 2
        prog2 = '{9'h0A0, 9'h04B, 9'h0A5, 9'h04C, 9'h040, 9'h110, 9'h0A3, 9'h023, 9'h0A1, 9'h04A, 9'h048,
                  9'h18A, 9'h050, 9'h1A3, 9'h0A0, 9'h04A, 9'h043, 9'h021, 9'h0AF, 9'h010, 9'h114};
        far_words = '{{11'h110, 9'h045}, {11'h1A1, 9'h044}, {11'h210, 9'h001}, {11'h211, 9'h1B5},
                      {11'h230, 9'h031}, {11'h231, 9'h1A0}, {11'h0A0, 9'h071}, {11'h0A1, 9'h140},
                      {11'h0C0, 9'h044}, {11'h0A2, 9'h0D5}, {11'h0A3, 9'h00A}, {11'h0A4, 9'h1A4}};
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        for (int i = 0; i < 21; i++) begin
            mem.rom_words[i] = prog2[i];
        end
        for (int i = 0; i < 12; i++) begin
            mem.rom_words[far_words[i][19:9]] = far_words[i][8:0];
        end
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 1000 && rom_addr != 11'h0A4; i++) begin
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        bus_read(REG_CORE, d);
        chk("core after second run", core_word(11'h0A4, 2'h3, 4'h4, 4'hA, 1'b0), d);
        bus_read(REG_CFG, d);
        chk("config after second run", cfg_word(2'h0, 3'h0, 4'h0, 4'h0, 4'h0, 1'b0), d);
        bus_read(REG_STATUS, d);
        chk("timer-2 event", 32'h2, d);
        stop_test();
    end
endmodule // four_bit_instruction_semantics_tb
